/* File: shared/dma_hold_pkg.sv */
/*
 * Constants and state type for the bus-master hold controller.
 * Assumes a single 10 MHz core clock whose rising edge stands for the
 * trailing edge of the phase-one system clock.
 */
package dma_hold_pkg;
    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int ADDR_W          = 16;
    localparam int DATA_W          = 16;
    localparam int CLK_PERIOD_NS   = 100;
    localparam int ACK_DROP_CYCLES = 2;   // Phase-one cycles the processor needs to drop ack
    localparam logic [1:0] ACK_DROP_CNT = 2'(ACK_DROP_CYCLES);
    localparam logic [1:0] BUF_CNT_RST  = 2'h0;
    localparam logic       SETUP_EN_RST = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACQUIRE,
        ST_SETUP,
        ST_OPEN,
        ST_WAIT,
        ST_CLOSE,
        ST_RELEASE
    } phase_t;
endpackage

/* File: logic/dma_bus_master_hold_control.sv */
/*
 * Bus-master hold controller: requests the memory bus from the processor,
 * runs memory cycles for a stream of transfer requests, then hands the bus back.
 * Assumes i_core_clk rises at the trailing edge of phase one, and that
 * bus_yield_ack and memory ready arrive asynchronously from the processor side.
 * Read data is taken straight off the data bus at the closing edge, where the
 * memory holds it stable; it is not passed through a synchroniser.
 */
`timescale 1ns/10ps
module dma_bus_master_hold_control
    import dma_hold_pkg::*;
#(
    parameter int AW = ADDR_W,   // Address width
    parameter int DW = DATA_W    // Data width
)(
    input  wire logic          i_core_clk,      // Core clock, phase-one trailing edge
    input  wire logic          i_rst,           // Asynchronous reset, active high
    input  wire logic          i_setup_en,      // Insert a setup state before opening
    input  wire logic          i_req_valid,     // Transfer request valid
    output logic               o_req_ready,     // Request accepted
    input  wire logic          i_req_write,     // Request is a write
    input  wire logic [AW-1:0] i_req_addr,      // Request address
    input  wire logic [DW-1:0] i_req_wdata,     // Request write data
    output logic               o_rsp_valid,     // Read data valid
    input  wire logic          i_rsp_ready,     // Read data taken
    output logic [DW-1:0]      o_rsp_rdata,     // Read data
    output logic               o_grant,         // Access grant to the local requester
    output logic               o_yield_req_oe_n,// Yield request pin: low pulls line low
    input  wire logic          i_bus_yield_ack, // Processor acknowledge (async)
    input  wire logic          i_mem_ready,     // Memory ready (async)
    output logic [AW-1:0]      o_addr,          // Address bus drive
    output logic               o_addr_oe_n,     // Address enable, low drives
    output logic [DW-1:0]      o_data,          // Data bus drive
    output logic               o_data_oe_n,     // Data enable, low drives
    input  wire logic [DW-1:0] i_data,          // Data bus sample
    output logic               o_read_direction_strobe,   // High for reads
    output logic               o_memory_cycle_enable_n,   // Memory cycle enable, active low
    output logic               o_write_strobe_n,          // Write strobe, active low
    output logic               o_direct_access_cycle_flag_n, // DMA cycle, active low
    output logic               o_cycle_complete_flag_n,   // Closing state, active low
    output logic               o_ctl_oe_n                 // Control line enable, low drives
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]    ack_sync;
        logic [1:0]    rdy_sync;
        phase_t        phase;
        logic [1:0]    drop_cnt;
        logic          req_write;
        logic [AW-1:0] req_addr;
        logic [DW-1:0] req_wdata;
        logic          req_full;
        logic          we;
        logic          grant;
        logic [DW-1:0] buf0;
        logic [DW-1:0] buf1;
        logic [1:0]    buf_cnt;
        logic          yield_on;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic ack;
    logic rdy;
    logic more;
    logic room;
    logic take_req;
    logic pop;

    assign ack  = s_q.ack_sync[1];
    assign rdy  = s_q.rdy_sync[1];
    // Reads need a free buffer slot so that a stalled receiver loses nothing
    assign room = (s_q.buf_cnt != 2'h2);
    assign more = i_req_valid && (!i_req_write ? (s_q.buf_cnt == 2'h0) : 1'b1);
    assign pop  = o_rsp_valid && i_rsp_ready;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d             = s_q;
        take_req        = 1'b0;
        s_d.ack_sync    = {s_q.ack_sync[0], i_bus_yield_ack};
        s_d.rdy_sync    = {s_q.rdy_sync[0], i_mem_ready};
        if (pop)
        begin
            s_d.buf0    = s_q.buf1;
            s_d.buf_cnt = s_q.buf_cnt - 2'h1;
        end
        case (s_q.phase)
            ST_IDLE:
            begin
                if (i_req_valid && !ack && room)
                begin
                    s_d.phase = ST_ACQUIRE;
                end
            end
            ST_ACQUIRE:
            begin
                if (ack)
                begin
                    take_req      = 1'b1;
                    s_d.grant     = 1'b1;
                    s_d.phase     = i_setup_en ? ST_SETUP : ST_OPEN;
                end
            end
            ST_SETUP:
            begin
                s_d.phase = ST_OPEN;
            end
            ST_OPEN:
            begin
                s_d.we    = s_q.req_write;
                s_d.phase = rdy ? ST_CLOSE : ST_WAIT;
            end
            ST_WAIT:
            begin
                if (rdy)
                begin
                    s_d.phase = ST_CLOSE;
                end
            end
            ST_CLOSE:
            begin
                s_d.we = 1'b0;
                if (!s_q.req_write)
                begin
                    if (pop)
                    begin
                        s_d.buf0 = (s_q.buf_cnt == 2'h2) ? s_q.buf1 : i_data;
                        s_d.buf1 = i_data;
                        s_d.buf_cnt = s_q.buf_cnt;
                    end
                    else if (s_q.buf_cnt == 2'h0)
                    begin
                        s_d.buf0    = i_data;
                        s_d.buf_cnt = 2'h1;
                    end
                    else
                    begin
                        s_d.buf1    = i_data;
                        s_d.buf_cnt = 2'h2;
                    end
                end
                // Block mode keeps the bus while writes, or reads with the read buffer empty, keep coming
                if (more)
                begin
                    take_req  = 1'b1;
                    s_d.phase = i_setup_en ? ST_SETUP : ST_OPEN;
                end
                else
                begin
                    s_d.grant    = 1'b0;
                    s_d.drop_cnt = ACK_DROP_CNT;
                    s_d.phase    = ST_RELEASE;
                end
            end
            ST_RELEASE:
            begin
                // Wait out the acknowledge drop before any new acquire
                if (s_q.drop_cnt != 2'h0)
                begin
                    s_d.drop_cnt = s_q.drop_cnt - 2'h1;
                end
                else if (!ack)
                begin
                    s_d.phase = ST_IDLE;
                end
            end
            default:
            begin
                s_d.phase = ST_IDLE;
            end
        endcase
        if (take_req)
        begin
            s_d.req_write = i_req_write;
            s_d.req_addr  = i_req_addr;
            s_d.req_wdata = i_req_wdata;
        end
        // Request pin comes from a flop so it never glitches between states
        s_d.yield_on = (s_d.phase inside {ST_ACQUIRE, ST_SETUP,
                                          ST_OPEN, ST_WAIT, ST_CLOSE});
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q          <= '0;
            s_q.phase    <= ST_IDLE;
            s_q.buf_cnt  <= BUF_CNT_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic drive;
    logic in_cycle;

    // Bus is ours from acquisition until the request drops
    assign drive    = (s_q.phase inside {ST_SETUP, ST_OPEN, ST_WAIT, ST_CLOSE});
    assign in_cycle = (s_q.phase inside {ST_OPEN, ST_WAIT, ST_CLOSE});

    assign o_req_ready      = take_req;
    assign o_rsp_valid      = (s_q.buf_cnt != 2'h0);
    assign o_rsp_rdata      = s_q.buf0;
    assign o_grant          = s_q.grant;
    assign o_yield_req_oe_n = !s_q.yield_on;
    assign o_addr           = s_q.req_addr;
    assign o_addr_oe_n      = !drive;
    assign o_data           = s_q.req_wdata;
    assign o_data_oe_n      = !(drive && s_q.req_write);
    assign o_ctl_oe_n       = !drive;
    assign o_read_direction_strobe      = drive && !s_q.req_write;
    assign o_memory_cycle_enable_n      = !drive;
    assign o_write_strobe_n             = !s_q.we;
    assign o_direct_access_cycle_flag_n = !(s_q.phase inside {ST_OPEN, ST_WAIT});
    assign o_cycle_complete_flag_n      = !(s_q.phase == ST_CLOSE);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence close_then_release;
        (s_q.phase == ST_CLOSE) && !more ##1 (s_q.phase == ST_RELEASE);
    endsequence

    a_release_no_access: assert property (@(posedge i_core_clk) disable iff (i_rst)
        close_then_release |-> (o_addr_oe_n && o_yield_req_oe_n) [*3])
        else $error("bus driven during release");
    a_acquire_on_ack: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_ACQUIRE) && ack |=> !o_addr_oe_n)
        else $error("acquire did not start cycle");
    a_drive_needs_req: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_addr_oe_n |-> !o_yield_req_oe_n)
        else $error("bus driven without request");
    a_wait_on_ready: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_WAIT) && !rdy |=> (s_q.phase == ST_WAIT))
        else $error("wait left without ready");
    a_complete_in_close: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_cycle_complete_flag_n |-> $past(in_cycle) && !o_memory_cycle_enable_n)
        else $error("complete flag outside cycle");
    a_write_setup: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_write_strobe_n) |-> !$past(o_addr_oe_n) && !o_data_oe_n)
        else $error("write strobe before address");
    a_grant_at_close: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_grant) |-> $past(s_q.phase) == ST_CLOSE)
        else $error("grant changed mid cycle");
    a_idle_needs_ack_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_RELEASE) ##1 (s_q.phase == ST_IDLE) |-> !$past(ack))
        else $error("new acquire before ack dropped");
    a_req_drop_at_end: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_yield_req_oe_n) |-> $past(s_q.phase) == ST_CLOSE)
        else $error("request dropped mid cycle");

    // ------------------------------------------------------------
    // Cycle shape and bus ownership
    // ------------------------------------------------------------
    sequence idle_then_acquire;
        (s_q.phase == ST_IDLE) ##1 (s_q.phase == ST_ACQUIRE);
    endsequence

    sequence open_then_close;
        (s_q.phase == ST_OPEN) ##1 (s_q.phase == ST_CLOSE);
    endsequence

    // Request goes out first; the bus stays floating until ack is seen
    a_acquire_requests: assert property (@(posedge i_core_clk) disable iff (i_rst)
        idle_then_acquire |-> !o_yield_req_oe_n && o_addr_oe_n)
        else $error("acquire without bus request");
    a_setup_then_open: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_SETUP) |=> (s_q.phase == ST_OPEN))
        else $error("setup state longer than one clock");
    a_open_one_state: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_OPEN) |=> (s_q.phase inside {ST_WAIT, ST_CLOSE}))
        else $error("opening state longer than one clock");
    a_close_one_state: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_CLOSE) |=> (s_q.phase inside {ST_SETUP, ST_OPEN, ST_RELEASE}))
        else $error("closing state longer than one clock");
    a_ready_ends_wait: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_WAIT) && rdy |=> (s_q.phase == ST_CLOSE))
        else $error("wait kept after ready");
    a_enable_static: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase inside {ST_SETUP, ST_OPEN, ST_WAIT}) |=>
            !o_memory_cycle_enable_n && !o_yield_req_oe_n)
        else $error("enable or request changed mid cycle");
    a_grant_static: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase inside {ST_OPEN, ST_WAIT}) |=> $stable(o_grant))
        else $error("grant changed before closing state");
    a_cycle_flag_span: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_direct_access_cycle_flag_n |-> !o_memory_cycle_enable_n && o_cycle_complete_flag_n)
        else $error("cycle flag outside opening or wait");
    a_strobe_in_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_write_strobe_n |-> !o_data_oe_n && !o_ctl_oe_n && !o_read_direction_strobe)
        else $error("write strobe without driven data");
    a_write_in_close: assert property (@(posedge i_core_clk) disable iff (i_rst)
        open_then_close |-> (o_write_strobe_n == !s_q.req_write))
        else $error("write strobe wrong in closing state");
    a_release_floats: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase == ST_RELEASE) |-> o_addr_oe_n && o_data_oe_n && o_ctl_oe_n)
        else $error("bus driven after request dropped");
    a_no_early_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase inside {ST_IDLE, ST_ACQUIRE}) |-> o_ctl_oe_n && o_addr_oe_n && o_data_oe_n)
        else $error("bus driven before acquisition");
    // Address and direction must not move under the memory mid cycle
    a_address_static: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (s_q.phase inside {ST_OPEN, ST_WAIT}) |=>
            $stable(o_addr) && $stable(o_read_direction_strobe))
        else $error("address or direction changed mid cycle");
    a_response_held: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_rdata))
        else $error("read data lost while stalled");
endmodule

/* File: testbench/cpu_hold_model.sv */
/*
 * Processor and memory side of the hold handshake.
 * Assumes the controller floats its bus when the ack is low.
 */
`timescale 1ns/10ps
module cpu_hold_model
    import dma_hold_pkg::*;
(
    input  wire logic              i_core_clk,       // Core clock
    input  wire logic              i_rst,            // Reset, active high
    input  wire logic [3:0]        i_lat,            // Grant latency in cycles
    input  wire logic              i_slow,           // Memory inserts waits
    input  wire logic              i_yield_req_oe_n, // Yield request, low active
    input  wire logic [ADDR_W-1:0] i_addr,           // Address from controller
    input  wire logic [DATA_W-1:0] i_wdata,          // Data from controller
    input  wire logic              i_ctl_oe_n,       // Control lines driven
    input  wire logic              i_data_oe_n,      // Data lines driven
    input  wire logic              i_read_dir,       // Read direction strobe
    input  wire logic              i_write_n,        // Write strobe
    input  wire logic              i_complete_n,     // Closing state flag
    output logic                   o_ack,            // Bus yield acknowledge
    output logic                   o_mem_ready,      // Memory ready
    output logic [DATA_W-1:0]      o_rd_data         // Data bus toward controller
);
    logic [3:0]        cnt_q;
    logic [1:0]        drop_q;
    logic [7:0]        lfsr_q;
    logic [DATA_W-1:0] mem [256];

    initial for (int i = 0; i < 256; i++) mem[i] = 16'(i) ^ 16'h5a3c;

    // Ack rises after the latency, falls two cycles after the request goes
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
        begin
            o_ack  <= 1'b0;
            cnt_q  <= 4'h0;
            drop_q <= 2'h0;
            lfsr_q <= 8'h5b;
        end
        else
        begin
            lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            drop_q <= 2'h0;
            if (!i_yield_req_oe_n)
            begin
                if (cnt_q >= i_lat) o_ack <= 1'b1;
                else cnt_q <= cnt_q + 4'h1;
            end
            else
            begin
                cnt_q <= 4'h0;
                if (o_ack) drop_q <= drop_q + 2'h1;
                if (o_ack && drop_q == 2'(ACK_DROP_CYCLES - 1)) o_ack <= 1'b0;
            end
        end

    always @(posedge i_core_clk)
        if (!i_ctl_oe_n && !i_write_n && !i_complete_n) mem[i_addr[7:0]] <= i_wdata;

    // Memory drives only on reads; otherwise the lines carry changing noise
    assign o_mem_ready = !i_slow | lfsr_q[0];
    assign o_rd_data = (!i_ctl_oe_n && i_read_dir && i_data_oe_n) ?
                       mem[i_addr[7:0]] : {lfsr_q, ~lfsr_q};
endmodule

/* File: testbench/dma_bus_master_hold_control_tb_top.sv */
/*
 * Self-checking bench for the hold controller with a reference model.
 * Assumes the processor model in cpu_hold_model.sv on the far side.
 */
`timescale 1ns/10ps
module dma_bus_master_hold_control_tb_top;
    import dma_hold_pkg::*;
    logic clk = 0, rst = 1, setup_en = 0, valid = 0, wr = 0, rsp_ready = 0;
    logic slow = 0, stall = 0, ack, mready, rdy, rvalid, grant, yoe_n, aoe_n, doe_n;
    logic rdir, memory_cycle_enable_n, we_n, direct_access_cycle_flag_n, comp_n, coe_n, yprev = 1;
    logic [15:0] addr = 0, wdata = 0, bus_a, bus_d, rd_in, rdata, exp_mem [256];
    logic [3:0]  lat = 1;
    logic [15:0] exp_q [$];
    int n_mismatch = 0, compares = 0, n_acc = 0, n_cyc = 0, cyc = 0, k;

    always #50 clk = ~clk;

    dma_bus_master_hold_control u_dma_bus_master_hold_control (
        .i_core_clk(clk), .i_rst(rst), .i_setup_en(setup_en), .i_req_valid(valid),
        .o_req_ready(rdy), .i_req_write(wr), .i_req_addr(addr), .i_req_wdata(wdata),
        .o_rsp_valid(rvalid), .i_rsp_ready(rsp_ready), .o_rsp_rdata(rdata),
        .o_grant(grant), .o_yield_req_oe_n(yoe_n), .i_bus_yield_ack(ack),
        .i_mem_ready(mready), .o_addr(bus_a), .o_addr_oe_n(aoe_n), .o_data(bus_d),
        .o_data_oe_n(doe_n), .i_data(rd_in), .o_read_direction_strobe(rdir),
        .o_memory_cycle_enable_n(memory_cycle_enable_n), .o_write_strobe_n(we_n),
        .o_direct_access_cycle_flag_n(direct_access_cycle_flag_n), .o_cycle_complete_flag_n(comp_n),
        .o_ctl_oe_n(coe_n));

    cpu_hold_model u_cpu_hold_model (
        .i_core_clk(clk), .i_rst(rst), .i_lat(lat), .i_slow(slow),
        .i_yield_req_oe_n(yoe_n), .i_addr(bus_a), .i_wdata(bus_d), .i_ctl_oe_n(coe_n),
        .i_data_oe_n(doe_n), .i_read_dir(rdir), .i_write_n(we_n), .i_complete_n(comp_n),
        .o_ack(ack), .o_mem_ready(mready), .o_rd_data(rd_in));

    // ------------------------------------------------------------
    // Checking and reference model
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial for (int i = 0; i < 256; i++) exp_mem[i] = 16'(i) ^ 16'h5a3c;

    // Cycle ceiling: a hung handshake ends the run as a failure
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            results();
        end
    end

    always @(posedge clk)
    begin
        rsp_ready <= !stall && ($urandom % 4 != 0);
        if (!rst)
        begin
            if (coe_n === 1'b0) chk(16'(yoe_n), 16'h0);
            if (aoe_n === 1'b0) chk(16'(ack), 16'h1);
            if (yprev === 1'b1 && yoe_n === 1'b0) chk(16'(ack), 16'h0);
            if (we_n === 1'b0) chk(16'(doe_n), 16'h0);
            chk(16'(memory_cycle_enable_n), 16'(coe_n));
            if (direct_access_cycle_flag_n === 1'b0) chk(16'({coe_n, comp_n}), 16'h1);
            if (coe_n === 1'b0 && comp_n === 1'b0) n_cyc++;
            if (rvalid === 1'b1 && rsp_ready === 1'b1)
                chk(rdata, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
            if (valid && rdy === 1'b1)
            begin
                n_acc++;
                if (wr) exp_mem[addr[7:0]] = wdata;
                else exp_q.push_back(exp_mem[addr[7:0]]);
            end
        end
        yprev = yoe_n;
    end

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    // Payload stays put until the edge where the request is taken
    task automatic send();
        valid <= 1'b1;
        wr    <= 1'($urandom % 2);
        addr  <= 16'($urandom);
        wdata <= 16'($urandom);
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
            // A long-stalled reader is let go so a full read buffer can drain
            if (k == 40) stall = 0;
        end
        while (rdy !== 1'b1 && k < 300);
        chk(16'(k < 300), 16'h1);
    endtask

    initial
    begin
        void'($urandom(32'h6cea64d5));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int m = 0; m < 16; m++)
        begin
            @(posedge clk);
            setup_en <= m[0];
            slow     <= m[1];
            stall     = m[2];
            lat      <= 4'(1 + m % 9);
            // Single words steal one cycle, longer runs hold the bus while writes, or reads with the read buffer empty, keep coming
            repeat (m[3] ? 8 : 1) send();
            valid <= 1'b0;
            @(posedge clk);
            stall = 0;
            for (k = 0; k < 300 && (exp_q.size() != 0 || yoe_n !== 1'b1 || ack); k++)
                @(posedge clk);
            chk(16'(yoe_n), 16'h1);
            chk(16'(grant), 16'h0);
        end
        chk(16'(n_cyc), 16'(n_acc));
        results();
    end
endmodule
